//--- src/phycm_top.v
// Collision, speed select, receive clock and management pin logic with an AHB-Lite register port.
//
// Notes on behaviour
// [R1] Speed select output is low for 10 Mb/s and high for 100 Mb/s.
// [R2] Block is held in reset while the active-low hardware reset pin is low; the code holds only the functional logic, and the register port keeps running.
// [R3] Collision asserts when receive activity is seen while transmit enable is high.
// [R4] At 10 Mb/s receive activity comes from the unsquelched receive signal.
// [R5] At 100 Mb/s activity means a 10-bit symbol holds two non-adjacent zeros.
// [R6] Collision output is not aligned to receive or transmit clocks; MAC synchronises it.
// [R7] In full duplex the collision output stays low.
// [R8] Collision asserts during the quality test unless the suppress bit is set.
// [R9] The station manager sources the management clock, never this block.
// [R10] Every management transfer is timed from management clock edges.
// [R11] The system supplies the 25 MHz reference clock; the code divides the receive clock from a 250 MHz system clock.
// [R12] Management data is driven and sampled only in step with the management clock; the code switches the output enable on the system clock.
// [R13] Receive clock is 25 MHz at 100 Mb/s and 2.5 MHz at 10 Mb/s.
`timescale 1ns/1ps
`include "phycm_defines.vh"
module phycm_top #(
    parameter RXC_FAST_HALF = `PHYCM_RXC_FAST_HALF,
    parameter RXC_SLOW_HALF = `PHYCM_RXC_SLOW_HALF,
    parameter SQE_CYC = `PHYCM_SQE_CYC
) (
    // Clock and reset.
    input wire clk_sys_i,
    input wire rst_i,
    // AHB-Lite slave.
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output wire hreadyout_o,
    output wire hresp_o,
    output wire [31:0] hrdata_o,
    // Interrupt.
    output wire irq_o,
    // Hardware reset pin.
    input wire hw_reset_low_i,
    // Medium and MAC side.
    input wire tx_en_i,
    input wire rx_unsq_i,
    input wire [9:0] rx_sym_i,
    input wire rx_sym_vld_i,
    output wire col_o,
    output wire speed_select_out_o,
    output wire rx_clk_o,
    // Management pins.
    input wire mdc_i,
    input wire mdio_i,
    output wire mdio_o,
    output wire mdio_oe_n_o
);
    // Decodes a byte address to a register index.
    function [2:0] dec_idx;
        input [31:0] addr;
        begin
            if (addr == `PHYCM_OFF_CTRL) begin
                dec_idx = `PHYCM_IDX_CTRL;
            end else if (addr == `PHYCM_OFF_STAT) begin
                dec_idx = `PHYCM_IDX_STAT;
            end else if (addr == `PHYCM_OFF_MASK) begin
                dec_idx = `PHYCM_IDX_MASK;
            end else if (addr == `PHYCM_OFF_STATE) begin
                dec_idx = `PHYCM_IDX_STATE;
            end else if (addr == `PHYCM_OFF_MRX) begin
                dec_idx = `PHYCM_IDX_MRX;
            end else if (addr == `PHYCM_OFF_MTX) begin
                dec_idx = `PHYCM_IDX_MTX;
            end else begin
                dec_idx = `PHYCM_IDX_NONE;
            end
        end
    endfunction

    // True when two zeros of the symbol are separated by at least one bit.
    function split_zeros;
        input [9:0] sym;
        integer i;
        integer j;
        begin
            split_zeros = 1'b0;
            for (i = 0; i < 10; i = i + 1) begin
                for (j = i + 2; j < 10; j = j + 1) begin
                    if (!sym[i] && !sym[j]) begin
                        split_zeros = 1'b1;
                    end
                end
            end
        end
    endfunction

    wire [4:0] sync_w;
    wire hwrst_n_s;
    wire tx_en_s;
    wire rx_unsq_s;
    wire mdc_s;
    wire mdio_s;

    phycm_sync #(
        .W(5)
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .async_i({hw_reset_low_i, tx_en_i, rx_unsq_i, mdc_i, mdio_i}),
        .sync_o(sync_w)
    );
    assign hwrst_n_s = sync_w[4];
    assign tx_en_s = sync_w[3];
    assign rx_unsq_s = sync_w[2];
    assign mdc_s = sync_w[1];
    assign mdio_s = sync_w[0];

    // Functional logic is held while either reset is active.
    wire fr = rst_i | ~hwrst_n_s; // [R2]

    // Bus and register state.
    reg hreadyout_ff;
    reg [31:0] hrdata_ff;
    reg wr_pend_ff;
    reg [2:0] wr_idx_ff;
    reg [`PHYCM_CTRL_W-1:0] ctrl_ff;
    reg [`PHYCM_EV_W-1:0] stat_ff;
    reg [`PHYCM_EV_W-1:0] mask_ff;
    reg irq_ff;
    reg [31:0] mtx_ff;
    reg [31:0] mrx_ff;

    // Functional state.
    reg hwrst_d_ff;
    reg tx_en_d_ff;
    reg mdc_d_ff;
    reg sym_act_ff;
    reg [15:0] sqe_cnt_ff;
    reg col_ff;
    reg speed_ff;
    reg rxc_ff;
    reg [7:0] rxc_cnt_ff;
    reg [31:0] sh_rx_ff;
    reg [31:0] sh_tx_ff;
    reg [4:0] bit_cnt_ff;
    reg mdio_o_ff;
    reg mdio_oe_n_ff;

    wire ahb_take = hsel_i & htrans_i[1] & hready_i;
    wire [2:0] a_idx = dec_idx(haddr_i);
    wire rd_stat = ahb_take & ~hwrite_i & (a_idx == `PHYCM_IDX_STAT);
    wire mtx_wr = wr_pend_ff & (wr_idx_ff == `PHYCM_IDX_MTX);

    wire mdc_rise = mdc_s & ~mdc_d_ff; // [R10]
    wire mdc_fall = ~mdc_s & mdc_d_ff; // [R10]
    wire frame_done = mdc_rise & (bit_cnt_ff == 5'h1F);

    wire sqe_on = (sqe_cnt_ff != 16'h0000);
    wire rx_act = ctrl_ff[`PHYCM_CTRL_SPEED] ? sym_act_ff : rx_unsq_s; // [R4] [R5]
    wire col_src = (tx_en_s & rx_act) | (sqe_on & ~ctrl_ff[`PHYCM_CTRL_SUPPRESS]); // [R3] [R8]
    wire nxt_col = ~fr & ~ctrl_ff[`PHYCM_CTRL_FDX] & col_src; // [R7]

    wire [`PHYCM_EV_W-1:0] ev;
    assign ev[`PHYCM_EV_COL] = nxt_col & ~col_ff;
    assign ev[`PHYCM_EV_MGMT] = ~fr & frame_done;
    assign ev[`PHYCM_EV_HWRST] = hwrst_n_s & ~hwrst_d_ff;

    // Set wins over the read clear.
    wire [`PHYCM_EV_W-1:0] nxt_stat = (rd_stat ? {`PHYCM_EV_W{1'b0}} : stat_ff) | ev;

    wire [7:0] rxc_half = ctrl_ff[`PHYCM_CTRL_SPEED] ? RXC_FAST_HALF[7:0] : RXC_SLOW_HALF[7:0];

    reg [31:0] rd_val;
    always @* begin
        rd_val = 32'h0000_0000;
        if (a_idx == `PHYCM_IDX_CTRL) begin
            rd_val[`PHYCM_CTRL_W-1:0] = ctrl_ff;
        end else if (a_idx == `PHYCM_IDX_STAT) begin
            rd_val[`PHYCM_EV_W-1:0] = stat_ff;
        end else if (a_idx == `PHYCM_IDX_MASK) begin
            rd_val[`PHYCM_EV_W-1:0] = mask_ff;
        end else if (a_idx == `PHYCM_IDX_STATE) begin
            rd_val[`PHYCM_ST_COL] = col_ff;
            rd_val[`PHYCM_ST_SPEED] = speed_ff;
            rd_val[`PHYCM_ST_RXACT] = rx_act;
            rd_val[`PHYCM_ST_TXEN] = tx_en_s;
            rd_val[`PHYCM_ST_SQE] = sqe_on;
            rd_val[`PHYCM_ST_HWRST] = ~hwrst_n_s;
        end else if (a_idx == `PHYCM_IDX_MRX) begin
            rd_val = mrx_ff;
        end else if (a_idx == `PHYCM_IDX_MTX) begin
            rd_val = mtx_ff;
        end
    end

    // Register port: writes take two data-phase cycles so a following read sees them.
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            hreadyout_ff <= 1'b1;
            hrdata_ff <= 32'h0000_0000;
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= `PHYCM_IDX_NONE;
            ctrl_ff <= `PHYCM_CTRL_RST;
            stat_ff <= {`PHYCM_EV_W{1'b0}};
            mask_ff <= `PHYCM_MASK_RST;
            irq_ff <= 1'b0;
            mtx_ff <= 32'h0000_0000;
        end else begin
            stat_ff <= nxt_stat;
            irq_ff <= |(nxt_stat & mask_ff);
            if (wr_pend_ff) begin
                wr_pend_ff <= 1'b0;
                hreadyout_ff <= 1'b1;
                if (wr_idx_ff == `PHYCM_IDX_CTRL) begin
                    ctrl_ff <= hwdata_i[`PHYCM_CTRL_W-1:0];
                end else if (wr_idx_ff == `PHYCM_IDX_MASK) begin
                    mask_ff <= hwdata_i[`PHYCM_EV_W-1:0];
                end else if (wr_idx_ff == `PHYCM_IDX_MTX) begin
                    mtx_ff <= hwdata_i;
                end
            end else if (ahb_take && hwrite_i) begin
                wr_pend_ff <= 1'b1;
                wr_idx_ff <= a_idx;
                hreadyout_ff <= 1'b0;
            end else if (ahb_take) begin
                hrdata_ff <= rd_val;
            end
        end
    end

    // Collision, speed select and quality test timing.
    always @(posedge clk_sys_i) begin
        if (fr) begin
            hwrst_d_ff <= hwrst_n_s;
            tx_en_d_ff <= 1'b0;
            sym_act_ff <= 1'b0;
            sqe_cnt_ff <= 16'h0000;
            col_ff <= 1'b0;
            speed_ff <= 1'b0;
        end else begin
            hwrst_d_ff <= hwrst_n_s;
            tx_en_d_ff <= tx_en_s;
            if (rx_sym_vld_i) begin
                sym_act_ff <= split_zeros(rx_sym_i); // [R5]
            end
            if (tx_en_d_ff && !tx_en_s && !ctrl_ff[`PHYCM_CTRL_FDX]) begin
                sqe_cnt_ff <= SQE_CYC[15:0]; // [R8]
            end else if (sqe_on) begin
                sqe_cnt_ff <= sqe_cnt_ff - 16'h0001;
            end
            col_ff <= nxt_col; // [R3] [R6]
            speed_ff <= ctrl_ff[`PHYCM_CTRL_SPEED]; // [R1]
        end
    end

    // Receive clock divided from the system clock.
    always @(posedge clk_sys_i) begin
        if (fr) begin
            rxc_ff <= 1'b0;
            rxc_cnt_ff <= 8'h00;
        end else if (rxc_cnt_ff >= rxc_half - 8'h01) begin
            rxc_ff <= ~rxc_ff; // [R13]
            rxc_cnt_ff <= 8'h00;
        end else begin
            rxc_cnt_ff <= rxc_cnt_ff + 8'h01;
        end
    end

    // Management shifter: sample on clock rise, drive on clock fall.
    always @(posedge clk_sys_i) begin
        if (fr) begin
            mdc_d_ff <= mdc_s;
            sh_rx_ff <= 32'h0000_0000;
            sh_tx_ff <= 32'h0000_0000;
            bit_cnt_ff <= 5'h00;
            mrx_ff <= 32'h0000_0000;
            mdio_o_ff <= 1'b1;
            mdio_oe_n_ff <= 1'b1;
        end else begin
            mdc_d_ff <= mdc_s;
            mdio_oe_n_ff <= ~ctrl_ff[`PHYCM_CTRL_MDIO_DRV];
            if (mdc_rise) begin
                sh_rx_ff <= {sh_rx_ff[30:0], mdio_s}; // [R12]
                bit_cnt_ff <= bit_cnt_ff + 5'h01;
                if (frame_done) begin
                    mrx_ff <= {sh_rx_ff[30:0], mdio_s};
                end
            end
            if (mtx_wr) begin
                sh_tx_ff <= hwdata_i;
            end else if (mdc_fall) begin
                mdio_o_ff <= sh_tx_ff[31]; // [R12]
                sh_tx_ff <= {sh_tx_ff[30:0], 1'b1};
            end
        end
    end

    assign hreadyout_o = hreadyout_ff;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_ff;
    assign irq_o = irq_ff;
    assign col_o = col_ff;
    assign speed_select_out_o = speed_ff;
    assign rx_clk_o = rxc_ff;
    assign mdio_o = mdio_o_ff;
    assign mdio_oe_n_o = mdio_oe_n_ff;
endmodule // phycm_top

//--- src/phycm_defines.vh
// Register map, field positions, reset values and timing counts of the collision and mode block.
`ifndef PHYCM_DEFINES_VH
`define PHYCM_DEFINES_VH

// Register byte offsets.
`define PHYCM_OFF_CTRL 32'h0000_0000
`define PHYCM_OFF_STAT 32'h0000_0004
`define PHYCM_OFF_MASK 32'h0000_0008
`define PHYCM_OFF_STATE 32'h0000_000C
`define PHYCM_OFF_MRX 32'h0000_0010
`define PHYCM_OFF_MTX 32'h0000_0014

// Register indices used by the decoder.
`define PHYCM_IDX_CTRL 3'h0
`define PHYCM_IDX_STAT 3'h1
`define PHYCM_IDX_MASK 3'h2
`define PHYCM_IDX_STATE 3'h3
`define PHYCM_IDX_MRX 3'h4
`define PHYCM_IDX_MTX 3'h5
`define PHYCM_IDX_NONE 3'h7

// Control register fields.
`define PHYCM_CTRL_SPEED 0
`define PHYCM_CTRL_FDX 1
`define PHYCM_CTRL_SUPPRESS 2
`define PHYCM_CTRL_MDIO_DRV 3
`define PHYCM_CTRL_W 4
`define PHYCM_CTRL_RST 4'h0

// Event bits of the status and mask registers.
`define PHYCM_EV_COL 0
`define PHYCM_EV_MGMT 1
`define PHYCM_EV_HWRST 2
`define PHYCM_EV_W 3
`define PHYCM_MASK_RST 3'h0

// State register fields.
`define PHYCM_ST_COL 0
`define PHYCM_ST_SPEED 1
`define PHYCM_ST_RXACT 2
`define PHYCM_ST_TXEN 3
`define PHYCM_ST_SQE 4
`define PHYCM_ST_HWRST 5

// Timing in picoseconds and nanoseconds, with derived cycle counts.
`define PHYCM_CLK_PS 4000
`define PHYCM_RXC_FAST_PS 40000
`define PHYCM_RXC_SLOW_PS 400000
`define PHYCM_SQE_NS 1000
`define PHYCM_RXC_FAST_HALF (`PHYCM_RXC_FAST_PS / (2 * `PHYCM_CLK_PS))
`define PHYCM_RXC_SLOW_HALF (`PHYCM_RXC_SLOW_PS / (2 * `PHYCM_CLK_PS))
`define PHYCM_SQE_CYC ((`PHYCM_SQE_NS * 1000 + `PHYCM_CLK_PS - 1) / `PHYCM_CLK_PS)

// Management frame length in bits.
`define PHYCM_MGMT_BITS 32

`endif

//--- src/phycm_sync.v
// Two-flop synchroniser for a group of asynchronous input levels.
`timescale 1ns/1ps
module phycm_sync #(
    parameter W = 5
) (
    // Clock and reset.
    input wire clk_sys_i,
    input wire rst_i,
    // Asynchronous levels in, synchronised levels out.
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule // phycm_sync

//--- tb/phycm_top_assertions.sv
// Port-level assertions for the collision and mode block.
`timescale 1ns/1ps
module phycm_top_assertions (
    // Clock and reset.
    input wire clk_sys_i,
    input wire rst_i,
    // Register bus.
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire hready_i,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire irq_o,
    // Pins.
    input wire hw_reset_low_i,
    input wire tx_en_i,
    input wire col_o,
    input wire speed_select_out_o,
    input wire rx_clk_o,
    input wire mdc_i,
    input wire mdio_o,
    input wire mdio_oe_n_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire take = hsel_i && htrans_i[1] && hready_i;
    a_resp_okay: assert property (hresp_o == 1'b0)
        else $error("response not okay");
    a_write_wait: assert property (take && hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
        else $error("write wait state wrong");
    a_read_nowait: assert property (take && !hwrite_i |=> hreadyout_o)
        else $error("read stalled");
    a_irq_read_clear: assert property (take && !hwrite_i && haddr_i == 32'h4 |=> !irq_o)
        else $error("status read left irq high");
    a_col_has_tx: assert property ($rose(col_o) |-> $past(tx_en_i, 2) || $past(tx_en_i, 3)
        || $past(tx_en_i, 4) || $past(tx_en_i, 5)) else $error("collision without transmit");
    a_hwrst_quiet: assert property ((!hw_reset_low_i)[*4] |->
        !col_o && !speed_select_out_o && !rx_clk_o) else $error("outputs live in hw reset");
    a_rxclk_fast: assert property (speed_select_out_o && $changed(rx_clk_o) |=>
        ($stable(rx_clk_o) || !speed_select_out_o)[*4] ##1
        ($changed(rx_clk_o) || !speed_select_out_o)) else $error("fast rx clock half wrong");
    a_mdio_step: assert property ($changed(mdio_o) |-> !$past(mdc_i, 2) && !$past(mdc_i, 3))
        else $error("mdio changed off mdc fall");
    cover property ($rose(col_o));
    cover property ($rose(irq_o));
    cover property ($fell(mdio_oe_n_o));
endmodule // phycm_top_assertions
bind phycm_top phycm_top_assertions i_phycm_top_assertions (.*);

//--- tb/phycm_mgr_model.sv
// Station manager model that clocks a management word out MSB first.
`timescale 1ns/1ps
module phycm_mgr_model (
    // Management pins toward the block.
    output reg mdc_o,
    output reg mdio_o,
    output reg mdio_en_o
);
    initial begin
        mdc_o = 1'b0;
        mdio_o = 1'b1;
        mdio_en_o = 1'b0;
    end
    task send(input [31:0] word);
        integer i;
        begin
            #1;
            mdio_en_o = 1'b1;
            for (i = 31; i >= 0; i = i - 1) begin
                mdio_o = word[i];
                #16 mdc_o = 1'b1;
                #16 mdc_o = 1'b0;
            end
            mdio_en_o = 1'b0;
            mdio_o = 1'b1;
        end
    endtask
endmodule // phycm_mgr_model

//--- tb/tb_top.sv
// Self-checking bench for the collision, speed and management block.
`timescale 1ns/1ps
module tb_top;
    reg clk_sys_i = 1'b0;
    reg rst_i = 1'b1;
    reg hsel = 1'b0, hwrite = 1'b0, tx_en = 1'b0, unsq = 1'b0, vld = 1'b0, hwl = 1'b1;
    reg [1:0] htrans = 2'h0;
    reg [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    reg [9:0] sym = 10'h3FF;
    reg [14:0] rows [0:5];
    wire hrdy, col, spd, irq, mdc, mdio_m, men, mdio_d, moe_n, rxc;
    wire [31:0] hrdata;
    // The management line has a pull-up, so it reads high when nobody drives it.
    wire mdio_w = men ? mdio_m : (moe_n ? 1'b1 : mdio_d);
    reg [31:0] mcap;
    reg rxl;
    integer fails = 0, tests_run = 0, i, n;
    phycm_top #(.SQE_CYC(8)) i_phycm_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(), .hrdata_o(hrdata),
        .irq_o(irq), .hw_reset_low_i(hwl), .tx_en_i(tx_en), .rx_unsq_i(unsq), .rx_sym_i(sym),
        .rx_sym_vld_i(vld), .col_o(col), .speed_select_out_o(spd), .rx_clk_o(rxc),
        .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(mdio_d), .mdio_oe_n_o(moe_n));
    phycm_mgr_model i_phycm_mgr_model (.mdc_o(mdc), .mdio_o(mdio_m), .mdio_en_o(men));
    // The manager samples the block's data line on each rise of its own clock.
    always @(posedge mdc) mcap <= {mcap[30:0], mdio_d};
    // The system clock stands in for the reference from which the receive clock is divided.
    always #2 clk_sys_i = ~clk_sys_i;
    task cyc(input integer n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("BAD %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task bus(input w, input [31:0] a, input [31:0] d);
        begin
            hsel <= 1'b1;
            haddr <= a;
            hwrite <= w;
            htrans <= 2'h2;
            cyc(1);
            while (!hrdy) cyc(1);
            htrans <= 2'h0;
            hwdata <= d;
            cyc(1);
            while (!hrdy) cyc(1);
            q = hrdata;
        end
    endtask
    task results;
        begin
            $display("fails %0d tests_run %0d", fails, tests_run);
            if (fails == 0 && tests_run > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    initial begin
        #20000;
        fails = fails + 1;
        results;
    end
    initial begin
        rows[0] = {2'h0, 1'b1, 1'b1, 10'h3FF, 1'b1};
        rows[1] = {2'h0, 1'b1, 1'b0, 10'h3FF, 1'b0};
        rows[2] = {2'h2, 1'b1, 1'b1, 10'h3FF, 1'b0};
        rows[3] = {2'h1, 1'b1, 1'b0, 10'h17F, 1'b1};
        rows[4] = {2'h1, 1'b1, 1'b0, 10'h27F, 1'b0};
        rows[5] = {2'h1, 1'b0, 1'b0, 10'h17F, 1'b0};
        cyc(20);
        rst_i <= 1'b0;
        cyc(3);
        bus(0, 32'h0, 32'h0);
        chk(q, 32'h0);
        bus(0, 32'h20, 32'h0);
        chk(q, 32'h0);
        for (i = 0; i < 6; i = i + 1) begin
            bus(1, 32'h0, {30'h0, rows[i][14:13]});
            tx_en <= rows[i][12];
            unsq <= rows[i][11];
            sym <= rows[i][10:1];
            vld <= 1'b1;
            cyc(1);
            vld <= 1'b0;
            cyc(16);
            chk(col, rows[i][0]);
            chk(spd, rows[i][13]);
        end
        bus(1, 32'h0, 32'h0);
        tx_en <= 1'b1;
        cyc(8);
        tx_en <= 1'b0;
        cyc(7);
        chk(col, 1'b1);
        bus(1, 32'h0, 32'h4);
        tx_en <= 1'b1;
        cyc(8);
        tx_en <= 1'b0;
        repeat (14) begin
            cyc(1);
            chk(col, 1'b0);
        end
        bus(0, 32'h4, 32'h0);
        unsq <= 1'b1;
        tx_en <= 1'b1;
        cyc(8);
        chk(irq, 1'b0);
        bus(1, 32'h8, 32'h1);
        cyc(2);
        chk(irq, 1'b1);
        bus(0, 32'h4, 32'h0);
        chk(q, 32'h1);
        chk(irq, 1'b0);
        bus(1, 32'h0, 32'h1);
        hwl <= 1'b0;
        cyc(8);
        chk(col, 1'b0);
        chk(spd, 1'b0);
        bus(0, 32'hC, 32'h0);
        chk(q[5], 1'b1);
        hwl <= 1'b1;
        cyc(8);
        chk(spd, 1'b1);
        bus(0, 32'h4, 32'h0);
        chk(q[2], 1'b1);
        tx_en <= 1'b0;
        unsq <= 1'b0;
        bus(1, 32'h14, 32'h96C3_A50F);
        i_phycm_mgr_model.send(32'h5AF0_1E3C);
        cyc(6);
        bus(0, 32'h10, 32'h0);
        chk(q, 32'h5AF0_1E3C);
        // First rise sees the idle high level, then the word follows MSB first.
        chk(mcap, (32'h96C3_A50F >> 1) | 32'h8000_0000);
        bus(1, 32'h0, 32'h8);
        cyc(2);
        chk(moe_n, 1'b0);
        // Measure one whole half period of the receive clock at 10 Mb/s.
        rxl = rxc;
        while (rxc === rxl) cyc(1);
        rxl = rxc;
        n = 0;
        while (rxc === rxl && n < 200) begin
            cyc(1);
            n = n + 1;
        end
        chk(n, 50);
        results;
    end
endmodule // tb_top
